// [src/fmg_pkg.sv]
// Notes on behaviour
// R1: high input drop latches flag, opens high switch
// R2: low input drop latches flag, opens low switch
// R3: high clamping latches flag; switches stay closed
// R4: low clamping latches flag; switches stay closed
// R5: high current limit past 1.024 ms latches
// R6: low current limit past 1.024 ms latches
// R7: low early heat after 32 us latches
// R8: high early heat after 32 us latches
// R9: overheat latches flag, opens only that switch
// R10: enabled disable pin high opens both switches
// R11: select high: high switch follows its own input
// R12: low switch follows low input
// R13: on needs input, analog supply, no disable
// R14: select high, enable zero ignores disable pin
// R15: select low: table of both inputs, pin
// R16: registers reset to defaults, bus-independent
// R17: flags freeze; status0 write clears both
// R18: alert low until status0 write clears
// R19: switch-off fault clears monitor enable bit
// R20: two-flop synchroniser on every async input
// R21: filters are counters restarting on deassert
package fmg_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int OC_FILTER_NS  = 1024000;
  localparam int HEAT_WARN_NS  = 32000;
  localparam int OC_FILTER_CYC = (OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HEAT_WARN_CYC = (HEAT_WARN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLAIN_CYC     = 1;
  localparam int CNT_W         = 16;

  // condition channel positions
  localparam int C_HIN_OK  = 0;
  localparam int C_LIN_OK  = 1;
  localparam int C_INTERNAL_ANALOG_SUPPLY_OK = 2;
  localparam int C_HCLAMP  = 3;
  localparam int C_LCLAMP  = 4;
  localparam int C_HLIM    = 5;
  localparam int C_LLIM    = 6;
  localparam int C_HWARM   = 7;
  localparam int C_LWARM   = 8;
  localparam int C_HHOT    = 9;
  localparam int C_LHOT    = 10;
  localparam int C_PDPIN   = 11;
  localparam int C_FWSEL   = 12;
  localparam int NCOND     = 13;

  // register indices; byte address is four times the index
  localparam int          ADDR_W     = 5;
  localparam logic [2:0]  IDX_ID1    = 3'h0;
  localparam logic [2:0]  IDX_ID2    = 3'h1;
  localparam logic [2:0]  IDX_SCR0   = 3'h2;
  localparam logic [2:0]  IDX_SCR1   = 3'h3;
  localparam logic [2:0]  IDX_CTL    = 3'h4;
  localparam logic [2:0]  IDX_STAT0  = 3'h5;
  localparam logic [2:0]  IDX_STAT1  = 3'h6;
  localparam logic [7:0]  ID1_VAL    = 8'h5a;  // arbitrary value
  localparam logic [7:0]  ID2_VAL    = 8'h01;  // arbitrary value
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [5:0]  SCR_MASK   = 6'h3f;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // control fields
  localparam int CTL_PD_EN  = 7;
  localparam int CTL_GAIN   = 6;
  localparam int CTL_MON_EN = 2;
  // status0 fields
  localparam int S0_UV_H   = 7;
  localparam int S0_UV_L   = 6;
  localparam int S0_HOT_H  = 3;
  localparam int S0_HOT_L  = 2;
  localparam int S0_WARM_H = 1;
  localparam int S0_WARM_L = 0;
  // status1 fields
  localparam int S1_OC_H   = 7;
  localparam int S1_OC_L   = 6;
  localparam int S1_PD     = 3;
  localparam int S1_OV_H   = 1;
  localparam int S1_OV_L   = 0;

  function automatic int cond_delay(input int idx, input int oc_cyc);
    if (idx == C_HLIM || idx == C_LLIM) begin
      return oc_cyc;
    end else if (idx == C_HWARM || idx == C_LWARM) begin
      return HEAT_WARN_CYC;
    end
    return PLAIN_CYC;
  endfunction : cond_delay
endpackage : fmg_pkg

// [src/fmg_cond_if.sv]
`timescale 1ns/1ns
interface fmg_cond_if;
  import fmg_pkg::*;
  logic [NCOND-1:0] raw;
  logic [NCOND-1:0] clean;
  modport src (output raw, input clean);
  modport flt (input raw, output clean);
endinterface : fmg_cond_if

// [src/fmg_cond_filter.sv]
`timescale 1ns/1ns
module fmg_cond_filter import fmg_pkg::*; #(
  parameter int OC_CYC = OC_FILTER_CYC
) (
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  fmg_cond_if.flt   cif
);
  for (genvar i = 0; i < NCOND; i++) begin : g_ch
    localparam logic [CNT_W-1:0] DLY = CNT_W'(cond_delay(i, OC_CYC));
    logic             meta_q;
    logic             sync_q;
    logic [CNT_W-1:0] cnt_q;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else begin
        meta_q <= cif.raw[i];  // see R20
        sync_q <= meta_q;      // see R20
      end
    end
    // count restarts the moment the condition drops
    always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        cnt_q <= '0;
      end else if (!sync_q) begin
        cnt_q <= '0;  // see R21
      end else if (cnt_q != DLY) begin
        cnt_q <= cnt_q + 1'b1;  // see R21
      end
    end
    assign cif.clean[i] = (cnt_q == DLY);
  end
endmodule : fmg_cond_filter

// [src/fmg_fault_mgr.sv]
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module fmg_fault_mgr import fmg_pkg::*; #(
  parameter int OC_CYC = OC_FILTER_CYC
) (
  input  wire logic              mclk_i,
  input  wire logic              nrst_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  input  wire logic              high_rail_input_ok_i,
  input  wire logic              low_rail_input_ok_i,
  input  wire logic              internal_analog_supply_ok_i,
  input  wire logic              high_rail_clamp_i,
  input  wire logic              low_rail_clamp_i,
  input  wire logic              high_rail_limit_i,
  input  wire logic              low_rail_limit_i,
  input  wire logic              high_rail_early_heat_i,
  input  wire logic              low_rail_early_heat_i,
  input  wire logic              high_rail_overheat_i,
  input  wire logic              low_rail_overheat_i,
  input  wire logic              power_disable_pin_i,
  input  wire logic              firmware_disable_select_i,
  output logic                   high_rail_switch_state_o,
  output logic                   low_rail_switch_state_o,
  output logic                   fault_alert_n_o,
  output logic                   current_monitor_enable_o,
  output logic                   current_monitor_gain_o
);
  fmg_cond_if cif ();

  logic [7:0]        ctl_q, ctl_d, stat0_q, stat0_d, stat1_q, stat1_d;
  logic [5:0]        scr_q [2];
  logic              hin_q, lin_q, hi_on_q, lo_on_q, hot_lat_h_q, hot_lat_l_q;
  logic              alert_n_q;
  logic              aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0]        wbyte_q;
  logic              wstrb0_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q;

  assign cif.raw = {firmware_disable_select_i, power_disable_pin_i, low_rail_overheat_i,
                    high_rail_overheat_i, low_rail_early_heat_i, high_rail_early_heat_i,
                    low_rail_limit_i, high_rail_limit_i, low_rail_clamp_i, high_rail_clamp_i,
                    internal_analog_supply_ok_i, low_rail_input_ok_i, high_rail_input_ok_i};

  fmg_cond_filter #(.OC_CYC(OC_CYC)) u_filt (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .cif    (cif)
  );

  // ---------------- register bus ----------------
  wire              do_wr   = aw_full_q && w_full_q && !bvalid_q;
  wire [2:0]        wr_idx  = awaddr_q[ADDR_W-1:2];
  wire              wr_ok   = (awaddr_q[1:0] == 2'h0) && (wr_idx <= IDX_STAT1);
  wire              wr_en   = do_wr && wr_ok && wstrb0_q;
  wire              ar_take = s_axi_arvalid_i && !rvalid_q;
  wire [2:0]        rd_idx  = s_axi_araddr_i[ADDR_W-1:2];
  wire              rd_ok   = (s_axi_araddr_i[1:0] == 2'h0) && (rd_idx <= IDX_STAT1);
  wire              clr     = wr_en && (wr_idx == IDX_STAT0);
  logic [7:0]       rd_byte;

  assign s_axi_awready_o = !aw_full_q && !bvalid_q;
  assign s_axi_wready_o  = !w_full_q && !bvalid_q;
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;

  always_comb begin
    unique case (rd_idx)
      IDX_ID1:   rd_byte = ID1_VAL;
      IDX_ID2:   rd_byte = ID2_VAL;
      IDX_SCR0:  rd_byte = {2'h0, scr_q[0]};
      IDX_SCR1:  rd_byte = {2'h0, scr_q[1]};
      IDX_CTL:   rd_byte = ctl_q;
      IDX_STAT0: rd_byte = stat0_q;
      IDX_STAT1: rd_byte = stat1_q;
      default:   rd_byte = RST_BYTE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_full_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_full_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr_i;
    end else if (do_wr) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      w_full_q <= 1'b0;
      wbyte_q  <= RST_BYTE;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_full_q <= 1'b1;
      wbyte_q  <= s_axi_wdata_i[7:0];
      wstrb0_q <= s_axi_wstrb_i[0];
    end else if (do_wr) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_ok ? rd_byte : RST_BYTE};
      rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  for (genvar s = 0; s < 2; s++) begin : g_scr
    always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        scr_q[s] <= '0;  // see R16
      end else if (wr_en && (wr_idx == IDX_SCR0 + 3'(s))) begin
        scr_q[s] <= wbyte_q[5:0] & SCR_MASK;
      end
    end
  end

  // ---------------- fault and switch logic ----------------
  wire hin      = cif.clean[C_HIN_OK];
  wire lin      = cif.clean[C_LIN_OK];
  wire internal_analog_supply     = cif.clean[C_INTERNAL_ANALOG_SUPPLY_OK];
  wire fwsel    = cif.clean[C_FWSEL];
  wire pdpin    = cif.clean[C_PDPIN];
  wire pd_feat  = !fwsel || ctl_q[CTL_PD_EN];  // see R14
  wire pd_act   = pd_feat && pdpin;             // see R10
  wire uv_h_ev  = hin_q && !hin;                // see R1
  wire uv_l_ev  = lin_q && !lin;                // see R2
  wire any_q    = |{stat0_q, stat1_q};
  wire [7:0] ev0 = {uv_h_ev, uv_l_ev, 2'h0, cif.clean[C_HHOT], cif.clean[C_LHOT],
                    cif.clean[C_HWARM], cif.clean[C_LWARM]};  // see R7 see R8 see R9
  wire [7:0] ev1 = {cif.clean[C_HLIM], cif.clean[C_LLIM], 2'h0, pd_act, 1'b0,
                    cif.clean[C_HCLAMP], cif.clean[C_LCLAMP]};  // see R3 see R4 see R5 see R6
  // overheat latch ends only on input, supply or disable-pin cycling
  wire hot_clr_h = !hin || !lin || !internal_analog_supply || pdpin;
  wire hot_clr_l = !lin || !internal_analog_supply || pdpin;
  wire hot_h_d   = cif.clean[C_HHOT] || (hot_lat_h_q && !hot_clr_h);
  wire hot_l_d   = cif.clean[C_LHOT] || (hot_lat_l_q && !hot_clr_l);
  // select high: each rail stands on its own input; low: high rail needs both
  wire hi_on_d   = hin && internal_analog_supply && !pd_act && !hot_h_d && (fwsel || lin);  // see R11 see R13 see R15
  wire lo_on_d   = lin && internal_analog_supply && !pd_act && !hot_l_d;                    // see R12 see R13 see R15
  wire sw_off    = (hi_on_q && !hi_on_d) || (lo_on_q && !lo_on_d);

  // a new event in the clearing cycle is kept; otherwise flags freeze
  assign stat0_d = clr ? ev0 : (any_q ? stat0_q : ev0);  // see R17
  assign stat1_d = clr ? ev1 : (any_q ? stat1_q : ev1);  // see R17

  always_comb begin
    ctl_d = ctl_q;
    if (wr_en && wr_idx == IDX_CTL) begin
      ctl_d = wbyte_q;
    end
    // hardware clear beats a same-cycle software enable
    if (sw_off) begin
      ctl_d[CTL_MON_EN] = 1'b0;  // see R19
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_q   <= RST_BYTE;  // see R16
      stat0_q <= RST_BYTE;  // see R16
      stat1_q <= RST_BYTE;  // see R16
    end else begin
      ctl_q   <= ctl_d;
      stat0_q <= stat0_d;
      stat1_q <= stat1_d;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hin_q       <= 1'b0;
      lin_q       <= 1'b0;
      hi_on_q     <= 1'b0;
      lo_on_q     <= 1'b0;
      hot_lat_h_q <= 1'b0;
      hot_lat_l_q <= 1'b0;
      alert_n_q   <= 1'b1;
    end else begin
      hin_q       <= hin;
      lin_q       <= lin;
      hi_on_q     <= hi_on_d;  // see R1 see R9
      lo_on_q     <= lo_on_d;  // see R2 see R9
      hot_lat_h_q <= hot_h_d;
      hot_lat_l_q <= hot_l_d;
      alert_n_q   <= ~|{stat0_d, stat1_d};  // see R18
    end
  end

  assign high_rail_switch_state_o = hi_on_q;
  assign low_rail_switch_state_o  = lo_on_q;
  assign fault_alert_n_o          = alert_n_q;
  assign current_monitor_enable_o = ctl_q[CTL_MON_EN];
  assign current_monitor_gain_o   = ctl_q[CTL_GAIN];

  // ---------------- checks ----------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  AST_UV_HIGH: assert property ($fell(hin) && !any_q |=> stat0_q[S0_UV_H] && !fault_alert_n_o && !hi_on_q) // see R1
    else $error("high undervoltage not latched");
  AST_UV_LOW: assert property ($fell(lin) && !any_q |=> stat0_q[S0_UV_L] && !fault_alert_n_o && !lo_on_q) // see R2
    else $error("low undervoltage not latched");
  AST_OV_HIGH: assert property (cif.clean[C_HCLAMP] && !any_q |=> stat1_q[S1_OV_H] && !fault_alert_n_o) // see R3
    else $error("high clamp flag missing");
  AST_HOT_OPEN: assert property (cif.clean[C_HHOT] |=> !hi_on_q ##1 !hi_on_q) // see R9
    else $error("high switch closed during overheat");
  AST_PD_OPEN: assert property (pd_act |=> !hi_on_q && !lo_on_q) // see R10
    else $error("disable pin did not open switches");
  AST_TABLE: assert property (!fwsel && !lin |=> !hi_on_q && !lo_on_q) // see R15
    else $error("switch on without low input");
  AST_FREEZE: assert property (any_q && !clr |=> $stable(stat0_q) && $stable(stat1_q)) // see R17
    else $error("status changed while frozen");
  AST_CLEAR: assert property (clr && ev0 == RST_BYTE && ev1 == RST_BYTE |=> !any_q && fault_alert_n_o) // see R17
    else $error("status write did not clear");
  AST_ALERT: assert property (any_q |-> !fault_alert_n_o) // see R18
    else $error("alert high with flag set");
  AST_MON_OFF: assert property ($fell(hi_on_q) || $fell(lo_on_q) |-> !current_monitor_enable_o) // see R19
    else $error("monitor left enabled after switch off");
  AST_OV_LOW: assert property (cif.clean[C_LCLAMP] && !any_q |=> stat1_q[S1_OV_L] && !fault_alert_n_o) // see R4
    else $error("low clamp flag missing");
  AST_OC_HIGH: assert property (cif.clean[C_HLIM] && !any_q |=> stat1_q[S1_OC_H] && !fault_alert_n_o) // see R5
    else $error("high current flag missing");
  AST_OC_LOW: assert property (cif.clean[C_LLIM] && !any_q |=> stat1_q[S1_OC_L] && !fault_alert_n_o) // see R6
    else $error("low current flag missing");
  AST_WARM_LOW: assert property (cif.clean[C_LWARM] && !any_q |=> stat0_q[S0_WARM_L] && !fault_alert_n_o) // see R7
    else $error("low early heat flag missing");
  AST_WARM_HIGH: assert property (cif.clean[C_HWARM] && !any_q |=> stat0_q[S0_WARM_H] && !fault_alert_n_o) // see R8
    else $error("high early heat flag missing");
  AST_HOT_HIGH_SET: assert property (cif.clean[C_HHOT] && !any_q |=> stat0_q[S0_HOT_H] && !fault_alert_n_o) // see R9
    else $error("high overheat flag missing");
  AST_HOT_LOW: assert property (cif.clean[C_LHOT] && !any_q |=> stat0_q[S0_HOT_L] && !lo_on_q) // see R9
    else $error("low overheat not handled");
  AST_PD_FLAG: assert property (pd_act && !any_q |=> stat1_q[S1_PD] && !fault_alert_n_o) // see R10
    else $error("disable pin flag missing");
  AST_HI_INPUT: assert property (!hin |=> !hi_on_q) // see R11
    else $error("high switch closed without its input");
  AST_LO_INPUT: assert property (!lin |=> !lo_on_q) // see R12
    else $error("low switch closed without its input");
  AST_SUPPLY: assert property (!internal_analog_supply |=> !hi_on_q && !lo_on_q) // see R13
    else $error("switch closed without analog supply");
  AST_PD_IGNORE: assert property (fwsel && !ctl_q[CTL_PD_EN] && pdpin && !any_q |=> !stat1_q[S1_PD]) // see R14
    else $error("disable pin acted while feature off");
  AST_CLR_KEEP: assert property (clr |=> stat0_q == $past(ev0) && stat1_q == $past(ev1)) // see R17
    else $error("clearing write lost a same-cycle event");
  // a raw edge needs three clock edges to reach the filtered view
  AST_SYNC_DELAY: assert property ($rose(cif.clean[C_HCLAMP]) |-> $past(cif.raw[C_HCLAMP], 3)) // see R20
    else $error("condition bypassed the synchroniser");
  AST_B_ANSWER: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
                                 |=> ##1 s_axi_bvalid_o)
    else $error("write response late");
  AST_R_ANSWER: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read response late");
  AST_RESET_OUT: assert property (disable iff (1'b0) !nrst_i |-> fault_alert_n_o && !hi_on_q && !lo_on_q // see R16
                                  && !current_monitor_enable_o)
    else $error("outputs not at defaults in reset");

  COV_CLEAR: cover property (any_q ##1 clr);
  COV_OC: cover property ($rose(stat1_q[S1_OC_H]));
  COV_WARM: cover property ($rose(stat0_q[S0_WARM_L]));
  COV_PD: cover property ($rose(stat1_q[S1_PD]));
  COV_HOT: cover property ($rose(stat0_q[S0_HOT_H]));
endmodule : fmg_fault_mgr

// [dv/fmg_host.sv]
`timescale 1ns/1ns
module fmg_host import fmg_pkg::*; (
  input  wire logic              mclk_i,
  output logic [ADDR_W-1:0]      awaddr_o,
  output logic                   awvalid_o,
  input  wire logic              awready_i,
  output logic [31:0]            wdata_o,
  output logic [3:0]             wstrb_o,
  output logic                   wvalid_o,
  input  wire logic              wready_i,
  input  wire logic [1:0]        bresp_i,
  input  wire logic              bvalid_i,
  output logic                   bready_o,
  output logic [ADDR_W-1:0]      araddr_o,
  output logic                   arvalid_o,
  input  wire logic              arready_i,
  input  wire logic [31:0]       rdata_i,
  input  wire logic [1:0]        rresp_i,
  input  wire logic              rvalid_i,
  output logic                   rready_o,
  output logic                   tmo_o
);
  localparam int LIMIT = 200;
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o, tmo_o} = '0;
  end
  // released address lines show the inverse so a stale value never passes
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr_o  <= a;
    wdata_o   <= d;
    wstrb_o   <= 4'hf;
    awvalid_o <= 1'h1;
    wvalid_o  <= 1'h1;
    bready_o  <= 1'h1;
    do begin
      @(posedge mclk_i);
      n++;
      if (awready_i === 1'h1) awvalid_o <= 1'h0;
      if (wready_i === 1'h1) wvalid_o <= 1'h0;
    end while (bvalid_i !== 1'h1 && n < LIMIT);
    r = bresp_i;
    bready_o <= 1'h0;
    awaddr_o <= ~a;
    if (bvalid_i !== 1'h1) tmo_o <= 1'h1;
    @(posedge mclk_i);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr_o  <= a;
    arvalid_o <= 1'h1;
    rready_o  <= 1'h1;
    do begin
      @(posedge mclk_i);
      n++;
      if (arready_i === 1'h1) arvalid_o <= 1'h0;
    end while (rvalid_i !== 1'h1 && n < LIMIT);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'h0;
    araddr_o <= ~a;
    if (rvalid_i !== 1'h1) tmo_o <= 1'h1;
    @(posedge mclk_i);
  endtask : rd
  task automatic clear_status(input logic [31:0] d, output logic [1:0] r);
    wr({IDX_STAT0, 2'h0}, d, r);
  endtask : clear_status
endmodule : fmg_host

// [dv/test_dual_switch_fault_manager.sv]
`timescale 1ns/1ns
module test_dual_switch_fault_manager import fmg_pkg::*;;
  localparam int OC = 20;
  logic              mclk_i = 1'h0;
  logic              nrst_i = 1'h1;
  logic [NCOND-1:0]  cond_q = '0;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, rd_v, ctl;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, rsp;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, tmo, hsw, lsw, alert_n, mon_en, gain;
  logic [17:0]       ex;
  logic [31:0]       rng = 32'h0000_cb2b;
  int                err_count = 0;
  int                n_tests = 0;
  always #50 mclk_i = ~mclk_i;
  fmg_fault_mgr #(.OC_CYC(OC)) u_fmg_fault_mgr (
    .mclk_i(mclk_i), .nrst_i(nrst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready),
    .high_rail_input_ok_i(cond_q[C_HIN_OK]), .low_rail_input_ok_i(cond_q[C_LIN_OK]),
    .internal_analog_supply_ok_i(cond_q[C_INTERNAL_ANALOG_SUPPLY_OK]), .high_rail_clamp_i(cond_q[C_HCLAMP]),
    .low_rail_clamp_i(cond_q[C_LCLAMP]), .high_rail_limit_i(cond_q[C_HLIM]), .low_rail_limit_i(cond_q[C_LLIM]),
    .high_rail_early_heat_i(cond_q[C_HWARM]), .low_rail_early_heat_i(cond_q[C_LWARM]),
    .high_rail_overheat_i(cond_q[C_HHOT]), .low_rail_overheat_i(cond_q[C_LHOT]),
    .power_disable_pin_i(cond_q[C_PDPIN]), .firmware_disable_select_i(cond_q[C_FWSEL]),
    .high_rail_switch_state_o(hsw), .low_rail_switch_state_o(lsw), .fault_alert_n_o(alert_n),
    .current_monitor_enable_o(mon_en), .current_monitor_gain_o(gain)
  );
  fmg_host u_fmg_host (
    .mclk_i(mclk_i), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready), .wdata_o(wdata),
    .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid),
    .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
    .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready), .tmo_o(tmo)
  );
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // {status0, status1, high switch, low switch} per fault kind
  function automatic logic [17:0] model(input int k);
    case (k)
      0: return {8'h80, 8'h00, 2'h1};
      1: return {8'h40, 8'h00, 2'h2};
      2: return {8'h00, 8'h02, 2'h3};
      3: return {8'h00, 8'h01, 2'h3};
      4: return {8'h00, 8'h80, 2'h3};
      5: return {8'h00, 8'h40, 2'h3};
      6: return {8'h02, 8'h00, 2'h3};
      7: return {8'h01, 8'h00, 2'h3};
      8: return {8'h08, 8'h00, 2'h1};
      9: return {8'h04, 8'h00, 2'h2};
      10, 11: return {8'h00, 8'h08, 2'h0};
      default: return {8'h00, 8'h00, 2'h3};
    endcase
  endfunction : model
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc
  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
    u_fmg_host.rd(a, rd_v, rsp);
    check(what, {rsp, rd_v}, {er, e});
  endtask : rd_chk
  // undervoltage kinds drop the input, the rest raise their indication
  task automatic set_fault(input int k, input logic on);
    case (k)
      0: cond_q[C_HIN_OK] <= ~on;
      1: cond_q[C_LIN_OK] <= ~on;
      2: cond_q[C_HCLAMP] <= on;
      3: cond_q[C_LCLAMP] <= on;
      4: cond_q[C_HLIM] <= on;
      5: cond_q[C_LLIM] <= on;
      6: cond_q[C_HWARM] <= on;
      7: cond_q[C_LWARM] <= on;
      8: cond_q[C_HHOT] <= on;
      9: cond_q[C_LHOT] <= on;
      default: cond_q[C_PDPIN] <= on;
    endcase
  endtask : set_fault
  always @(posedge mclk_i) begin
    if (tmo === 1'h1) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    // a real falling edge, so the asynchronous reset branches run
    nrst_i <= 1'h0;
    cyc(3);
    nrst_i <= 1'h1;
    cyc(1);
    for (int i = 0; i < 8; i++) begin
      rd_chk("reset value", 5'(i * 4), (i == 0) ? {24'h0, ID1_VAL} : (i == 1) ? {24'h0, ID2_VAL} : 32'h0,
             (i == 7) ? RESP_SLVERR : RESP_OKAY);
    end
    for (int i = 2; i < 4; i++) begin
      rng = xs(rng);
      u_fmg_host.wr(5'(i * 4), rng, rsp);
      check("scratch write", rsp, RESP_OKAY);
      rd_chk("scratch", 5'(i * 4), rng & 32'h0000_003f, RESP_OKAY);
    end
    u_fmg_host.wr(5'h1c, rng, rsp);
    check("unmapped write", rsp, RESP_SLVERR);
    u_fmg_host.wr({IDX_CTL, 2'h0}, 32'h0000_0044, rsp);
    check("gain and monitor", {gain, mon_en, rsp}, {1'h1, 1'h1, RESP_OKAY});
    check("switches unpowered", {hsw, lsw}, 2'h0);
    cond_q[C_INTERNAL_ANALOG_SUPPLY_OK:C_HIN_OK] <= 3'h7;
    cond_q[C_FWSEL] <= 1'h1;
    cyc(8);
    check("switches powered", {hsw, lsw, alert_n}, 3'h7);
    // two pulses each shorter than the filter: total exceeds it only without restart
    repeat (2) begin
      cond_q[C_HLIM] <= 1'h1;
      cyc(OC - 4);
      cond_q[C_HLIM] <= 1'h0;
      cyc(2);
    end
    cyc(6);
    rd_chk("limit pulses", {IDX_STAT1, 2'h0}, 32'h0, RESP_OKAY);
    for (int k = 0; k < 13; k++) begin
      ex = model(k);
      ctl = (k == 10) ? 32'h0000_0084 : 32'h0000_0004;
      cond_q[C_FWSEL] <= (k != 11);
      u_fmg_host.wr({IDX_CTL, 2'h0}, ctl, rsp);
      cyc(8);
      check("monitor on", {gain, mon_en}, 2'h1);
      set_fault(k, 1'h1);
      cyc((k == 4 || k == 5) ? OC + 8 : (k == 6 || k == 7) ? HEAT_WARN_CYC + 8 : 8);
      check("alert", alert_n, k == 12);
      check("switches", {hsw, lsw}, ex[1:0]);
      rd_chk("status0", {IDX_STAT0, 2'h0}, ex[17:10], RESP_OKAY);
      rd_chk("status1", {IDX_STAT1, 2'h0}, ex[9:2], RESP_OKAY);
      rd_chk("control", {IDX_CTL, 2'h0}, (ex[1:0] == 2'h3) ? ctl : ctl & 32'h0000_00fb, RESP_OKAY);
      set_fault(k, 1'h0);
      cyc(2);
      if (k != 12) begin
        cond_q[C_INTERNAL_ANALOG_SUPPLY_OK:C_HIN_OK] <= 3'h0;
        cyc(8);
        check("switches supply low", {hsw, lsw}, 2'h0);
        cond_q[C_INTERNAL_ANALOG_SUPPLY_OK:C_HIN_OK] <= 3'h7;
        cyc(8);
        rd_chk("status0 frozen", {IDX_STAT0, 2'h0}, ex[17:10], RESP_OKAY);
        check("alert held", alert_n, 1'h0);
      end
      rng = xs(rng);
      u_fmg_host.clear_status(rng, rsp);
      cyc(4);
      rd_chk("status0 clear", {IDX_STAT0, 2'h0}, 32'h0, RESP_OKAY);
      rd_chk("status1 clear", {IDX_STAT1, 2'h0}, 32'h0, RESP_OKAY);
      check("restored", {hsw, lsw, alert_n}, 3'h7);
    end
    close_out();
  end
endmodule : test_dual_switch_fault_manager
